// ---- design/sct_lmfc.sv ----
// multiframe / extended multiblock timer with sysref and sync-request inputs
`timescale 1ns/100ps
module sct_lmfc #(
  parameter int PERIOD_8B = sct_pkg::LMFC_OCTETS,
  parameter int PERIOD_64B = sct_pkg::LEMC_OCTETS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic mode_64b,
  input wire logic sysref,
  input wire logic single_ended_sync_request_pin_b,
  input wire logic differential_marker_pair_b,
  input wire logic sync_sel_diff,
  sct_tim_if.timer tim
);
  import sct_pkg::*;

  // sync pins idle high and sysref idle low, so leaving reset shows no request and no false sysref edge
  localparam logic [2:0] PIN_IDLE = 3'h6;

  typedef struct packed {
    logic [2:0] m1;
    logic [2:0] m2;
    logic sr_old;
    logic seen;
    logic [TIM_W-1:0] cnt;
  } sct_tim_s;

  sct_tim_s q;
  sct_tim_s n;
  logic sr_rise;
  logic [TIM_W-1:0] last;

  //////////////////////////////////////////////////////////////////////////////
  assign sr_rise = q.m2[0] & ~q.sr_old;
  assign last = mode_64b ? TIM_W'(PERIOD_64B - 1) : TIM_W'(PERIOD_8B - 1);

  always_comb
  begin
    n = q;
    if (clk_en)
    begin
      n.m1 = {differential_marker_pair_b, single_ended_sync_request_pin_b, sysref};
      n.m2 = q.m1;
      n.sr_old = q.m2[0];
      if (sr_rise)
      begin
        n.cnt = '0; // R4
        n.seen = 1'b1;
      end
      else if (q.cnt >= last)
        n.cnt = '0;
      else
        n.cnt = q.cnt + TIM_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '{m1: PIN_IDLE, m2: PIN_IDLE, sr_old: 1'b0, seen: 1'b0, cnt: '0};
    else
      q <= n;
  end

  // the request is read only after both flops; low on the pin asks for sync
  assign tim.sync_req = sync_sel_diff ? ~q.m2[2] : ~q.m2[1]; // R8 R12
  assign tim.lmfc_edge = (q.cnt == '0) & clk_en;
  assign tim.sysref_seen = q.seen;

  //////////////////////////////////////////////////////////////////////////////
  AST_SYSREF_RESETS: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (clk_en && sr_rise) |=> (q.cnt == '0 && q.seen))
    else $error("sysref edge did not reset the multiframe counter");
  AST_PERIOD_WRAP: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (clk_en && q.cnt == last && !sr_rise) |=> (q.cnt == '0))
    else $error("multiframe counter did not wrap at its period");
  COV_SYSREF: cover property (@(posedge clk) disable iff (!rst_b) clk_en && sr_rise);
endmodule

// ---- design/sct_pkg.sv ----
// constants and types shared by the converter link transmitter
package sct_pkg;
  localparam int LANES = 16;
  localparam int LANES_PER_GROUP = 8;
  localparam int OCTET_W = 8;
  localparam int WORD_W = 66;
  localparam int PAY_W = 64;
  localparam int SCR8_W = 15;
  localparam int SCR64_W = 58;
  localparam int TIM_W = 16;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [1:0] SH_DATA = 2'h1;
  localparam logic [2:0] OCT_LAST = 3'h7;
  localparam logic [2:0] ILAS_LAST = 3'h3;
  localparam logic [14:0] SCR8_SEED = 15'h0000;
  localparam logic [57:0] SCR64_SEED = 58'h0;
  // frames x octets per multiframe, and 32 blocks of 8 octets per multiblock
  localparam int LMFC_OCTETS = 32;
  localparam int LEMC_OCTETS = 256;
  typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA, ST_B66} sct_link_e;
endpackage

// ---- design/sct_tim_if.sv ----
// timing carrier between the multiframe timer and the lane logic
`timescale 1ns/100ps
interface sct_tim_if;
  logic lmfc_edge;
  logic sync_req;
  logic sysref_seen;
  modport timer (output lmfc_edge, output sync_req, output sysref_seen);
  modport link (input lmfc_edge, input sync_req, input sysref_seen);
endinterface

// ---- design/sct_tx.sv ----
// lane-level link transmitter: comma, alignment, data and 64b/66b block framing
// Functional notes
// R1: each lane carries 8b/10b characters or 64b/66b blocks; no 64b/80b mode.
// R2: sixteen lanes, split into two groups of eight.
// R3: 64b/66b uses sync headers; the sync request is ignored there.
// R4: sysref resets the multiframe or extended multiblock counter.
// R5: no command channel; 64b/66b payload is sample data only.
// R6: forward error correction can be enabled in 64b/66b mode.
// R7: no CRC3 bits are generated in 64b/66b mode.
// R8: sync request comes on a single-ended pin or a differential pair.
// R9: subclass 1 only, timed by the multiframe clock; subclass 0 receivers work.
// R10: all lanes of the link stay aligned to one timing.
// R11: no multipoint lane alignment, no multipoint reference input.
// R12: sync request sampling and response timing follow the earliest interface revision.
// R13: 8b/10b formats stay usable by previous-revision receivers.
// R14: while sync is requested in 8b/10b mode, every lane sends K28.5.
// R15: receiver syncs after four commas and releases request on an LMFC edge.
// R16: 64b/66b always scrambled; 8b/10b scrambled only if enabled, never in alignment.
// R17: serializers and link logic run from the single device clock.
`timescale 1ns/100ps
module sct_tx #(
  parameter int PERIOD_8B = sct_pkg::LMFC_OCTETS,
  parameter int PERIOD_64B = sct_pkg::LEMC_OCTETS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic mode_64b,
  input wire logic fec_en,
  input wire logic scrambler_enable_bit,
  input wire logic sync_sel_diff,
  input wire logic sysref,
  input wire logic single_ended_sync_request_pin_b,
  input wire logic differential_marker_pair_b,
  input wire logic [sct_pkg::LANES*sct_pkg::OCTET_W-1:0] sample_data,
  output logic sample_ready,
  output logic [sct_pkg::LANES_PER_GROUP*sct_pkg::WORD_W-1:0] lane_group_a,
  output logic [sct_pkg::LANES_PER_GROUP*sct_pkg::WORD_W-1:0] lane_group_b,
  output logic [sct_pkg::LANES-1:0] lane_is_k,
  output logic lane_valid,
  output logic lane_mode_64b,
  output logic fec_active,
  output logic link_data,
  output logic sysref_seen
);
  import sct_pkg::*;

  typedef struct packed {
    sct_link_e st;
    logic [2:0] mf_cnt;
    logic [2:0] oct_idx;
    logic [LANES-1:0][PAY_W-1:0] acc;
    logic [LANES-1:0][SCR8_W-1:0] s8;
    logic [LANES-1:0][SCR64_W-1:0] s64;
    logic [LANES-1:0][WORD_W-1:0] word;
    logic [LANES-1:0] is_k;
    logic valid;
    logic fec;
    logic was64;
  } sct_tx_s;

  sct_tx_s q;
  sct_tx_s n;
  logic [2:0] cur_idx;
  logic [SCR8_W+OCTET_W-1:0] r8;
  logic [SCR64_W+PAY_W-1:0] r64;

  sct_tim_if tim ();

  // one timer serves every lane so the whole link shares one alignment
  sct_lmfc #(
    .PERIOD_8B(PERIOD_8B),
    .PERIOD_64B(PERIOD_64B)
  ) u_lmfc (
    .clk(clk), // R17
    .rst_b(rst_b),
    .clk_en(clk_en),
    .mode_64b(mode_64b),
    .sysref(sysref),
    .single_ended_sync_request_pin_b(single_ended_sync_request_pin_b),
    .differential_marker_pair_b(differential_marker_pair_b),
    .sync_sel_diff(sync_sel_diff),
    .tim(tim)
  );

  //////////////////////////////////////////////////////////////////////////////
  // self-synchronous scramblers, msb first; taps are the previous outputs
  function automatic logic [SCR8_W+OCTET_W-1:0] scr8_f(logic [SCR8_W-1:0] s, logic [OCTET_W-1:0] d);
    logic [OCTET_W-1:0] o;
    o = '0;
    for (int b = OCTET_W - 1; b >= 0; b--)
    begin
      o[b] = d[b] ^ s[13] ^ s[14];
      s = {s[SCR8_W-2:0], o[b]};
    end
    return {s, o};
  endfunction

  function automatic logic [SCR64_W+PAY_W-1:0] scr64_f(logic [SCR64_W-1:0] s, logic [PAY_W-1:0] d);
    logic [PAY_W-1:0] o;
    o = '0;
    for (int b = PAY_W - 1; b >= 0; b--)
    begin
      o[b] = d[b] ^ s[38] ^ s[57];
      s = {s[SCR64_W-2:0], o[b]};
    end
    return {s, o};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // block boundaries restart on every extended multiblock edge
  assign cur_idx = tim.lmfc_edge ? '0 : q.oct_idx;

  always_comb
  begin
    n = q;
    r8 = '0;
    r64 = '0;
    if (clk_en)
    begin
      n.fec = mode_64b & fec_en; // R6
      n.was64 = (q.st == ST_B66);
      n.valid = 1'b0;
      case (q.st)
        ST_CGS:
          if (mode_64b)
            n.st = ST_B66;
          else if (!tim.sync_req && tim.lmfc_edge) // R15 R9
          begin
            n.st = ST_ILAS;
            n.mf_cnt = '0;
          end
        ST_ILAS:
          if (mode_64b)
            n.st = ST_B66;
          else if (tim.sync_req)
            n.st = ST_CGS; // R12
          else if (tim.lmfc_edge)
          begin
            if (q.mf_cnt == ILAS_LAST)
              n.st = ST_DATA;
            else
              n.mf_cnt = q.mf_cnt + 3'h1;
          end
        ST_DATA:
          if (mode_64b)
            n.st = ST_B66;
          else if (tim.sync_req)
            n.st = ST_CGS; // R12
        ST_B66:
          if (!mode_64b)
            n.st = ST_CGS; // R3
        default:
          n.st = ST_CGS;
      endcase
      n.oct_idx = cur_idx + 3'h1;
      for (int i = 0; i < LANES; i++) // R10
      begin
        if (q.st == ST_B66)
        begin
          n.acc[i] = {q.acc[i][PAY_W-OCTET_W-1:0], sample_data[i*OCTET_W+:OCTET_W]};
          n.is_k[i] = 1'b0;
          if (cur_idx == OCT_LAST)
          begin
            r64 = scr64_f(q.s64[i], n.acc[i]); // R16
            n.s64[i] = r64[SCR64_W+PAY_W-1:PAY_W];
            // header is always plain data: no command channel, no crc3 bits
            n.word[i] = {SH_DATA, r64[PAY_W-1:0]}; // R1 R5 R7
            n.valid = 1'b1;
          end
        end
        else
        begin
          n.valid = 1'b1;
          if (q.st == ST_CGS)
          begin
            n.word[i] = WORD_W'(K28_5); // R14 R13
            n.is_k[i] = 1'b1;
          end
          else if (q.st == ST_DATA && scrambler_enable_bit)
          begin
            r8 = scr8_f(q.s8[i], sample_data[i*OCTET_W+:OCTET_W]); // R16
            n.s8[i] = r8[SCR8_W+OCTET_W-1:OCTET_W];
            n.word[i] = WORD_W'(r8[OCTET_W-1:0]);
            n.is_k[i] = 1'b0;
          end
          else
          begin
            // alignment period and unscrambled data pass octets untouched
            n.word[i] = WORD_W'(sample_data[i*OCTET_W+:OCTET_W]); // R16
            n.is_k[i] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= ST_CGS;
      q.s8 <= {LANES{SCR8_SEED}};
      q.s64 <= {LANES{SCR64_SEED}};
    end
    else
      q <= n;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sixteen lanes leave as two groups of eight; no multipoint reference exists
  assign lane_group_a = q.word[LANES_PER_GROUP-1:0]; // R2 R11
  assign lane_group_b = q.word[LANES-1:LANES_PER_GROUP]; // R2
  assign lane_is_k = q.is_k;
  assign lane_valid = q.valid;
  assign lane_mode_64b = q.was64;
  assign fec_active = q.fec;
  assign link_data = (q.st == ST_DATA) | (q.st == ST_B66);
  assign sysref_seen = tim.sysref_seen;
  // commas carry no samples, so the source is held off while they go out
  assign sample_ready = clk_en & (q.st != ST_CGS);

  //////////////////////////////////////////////////////////////////////////////
  AST_CGS_COMMA: assert property (@(posedge clk) disable iff (!rst_b) // R14
    (clk_en && q.st == ST_CGS) |=> (q.is_k == '1 && q.word[0] == WORD_W'(K28_5)
      && q.word[LANES-1] == WORD_W'(K28_5) && q.valid))
    else $error("comma stream missing during code group sync");
  AST_B66_IGNORES_SYNC: assert property (@(posedge clk) disable iff (!rst_b) // R3
    (clk_en && q.st == ST_B66 && mode_64b) |=> (q.st == ST_B66 && q.is_k == '0))
    else $error("64b/66b mode left on sync request");
  AST_SYNC_HEADER: assert property (@(posedge clk) disable iff (!rst_b) // R7
    (lane_valid && lane_mode_64b) |-> (q.word[0][WORD_W-1:PAY_W] == SH_DATA
      && q.word[LANES-1][WORD_W-1:PAY_W] == SH_DATA))
    else $error("block header is not a data header");
  AST_ILAS_PLAIN: assert property (@(posedge clk) disable iff (!rst_b) // R16
    (clk_en && q.st == ST_ILAS) |=> (q.word[0] == WORD_W'($past(sample_data[OCTET_W-1:0]))))
    else $error("alignment octet was altered");
  AST_DATA_UNSCR: assert property (@(posedge clk) disable iff (!rst_b) // R16
    (clk_en && q.st == ST_DATA && !scrambler_enable_bit)
      |=> (q.word[1] == WORD_W'($past(sample_data[2*OCTET_W-1:OCTET_W]))))
    else $error("data scrambled while scrambler disabled");
  AST_CGS_EXIT: assert property (@(posedge clk) disable iff (!rst_b) // R15
    (clk_en && q.st == ST_CGS && !mode_64b && !tim.sync_req && tim.lmfc_edge) |=> q.st == ST_ILAS)
    else $error("no alignment start on multiframe edge after sync release");
  AST_SYNC_RESTART: assert property (@(posedge clk) disable iff (!rst_b) // R12
    (clk_en && q.st == ST_DATA && !mode_64b && tim.sync_req) |=> q.st == ST_CGS)
    else $error("sync request did not restart code group sync");
  AST_FEC_FLAG: assert property (@(posedge clk) disable iff (!rst_b) // R6
    clk_en |=> (fec_active == ($past(mode_64b) && $past(fec_en))))
    else $error("fec flag does not follow configuration");
  AST_BLOCK_SPACING: assert property (@(posedge clk) disable iff (!rst_b) // R1
    (lane_valid && lane_mode_64b && clk_en && mode_64b && !tim.lmfc_edge) |=> !lane_valid [*7])
    else $error("64b/66b blocks closer than eight octets");
  COV_CGS_TO_ILAS: cover property (@(posedge clk) disable iff (!rst_b) q.st == ST_CGS ##1 q.st == ST_ILAS);
  COV_ILAS_TO_DATA: cover property (@(posedge clk) disable iff (!rst_b) q.st == ST_ILAS ##1 q.st == ST_DATA);
  COV_BLOCK_OUT: cover property (@(posedge clk) disable iff (!rst_b) lane_valid && lane_mode_64b);
endmodule

// ---- tb/sct_rx_model.sv ----
// behavioural receiver on the far side: sync request handshake driven by comma count
`timescale 1ns/100ps
module sct_rx_model #(
  parameter int PERIOD = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sysref,
  input wire logic want_link,
  input wire logic use_diff,
  input wire logic comma_seen,
  output logic se_b,
  output logic diff_b
);
  int lmfc_q;
  int commas_q;
  logic done_q;
  logic sysref_q;
  logic req_low;
  // request only while the link is wanted and not yet synchronised
  assign req_low = want_link & ~done_q;
  // the unused pin idles high, as a released pin with pull-up would
  assign se_b = ~(req_low & ~use_diff);
  assign diff_b = ~(req_low & use_diff);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lmfc_q <= 0;
      commas_q <= 0;
      done_q <= 1'b0;
      sysref_q <= 1'b0;
    end
    else
    begin
      sysref_q <= sysref;
      lmfc_q <= (sysref & ~sysref_q) ? 0 : (lmfc_q + 1) % PERIOD;
      commas_q <= (comma_seen & req_low) ? commas_q + 1 : 0;
      // four commas in a row, then release on the own multiframe edge
      if (!want_link)
        done_q <= 1'b0;
      else if (commas_q >= 4 && lmfc_q == 0)
        done_q <= 1'b1;
    end
  end
endmodule

// ---- tb/tb_sct_tx.sv ----
// self-checking bench for the converter link transmitter
`timescale 1ns/100ps
module tb_sct_tx;
  import sct_pkg::*;
  localparam int P8 = 8;
  localparam int P64 = 16;
  logic clk, rst_b, clk_en, mode_64b, fec_en, scr_en, sel_diff, sysref, want;
  logic se_b, diff_b, sample_ready, lane_valid, lane_mode_64b, fec_active, link_data, sysref_seen;
  logic [LANES*OCTET_W-1:0] sample_data;
  logic [LANES_PER_GROUP*WORD_W-1:0] grp_a, grp_b;
  logic [LANES-1:0] lane_is_k;
  logic [2*LANES_PER_GROUP*WORD_W-1:0] all_w;
  int fails, cmp_count, n;
  assign all_w = {grp_b, grp_a};
  sct_tx #(.PERIOD_8B(P8), .PERIOD_64B(P64)) sct_tx_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .mode_64b(mode_64b), .fec_en(fec_en), .scrambler_enable_bit(scr_en), .sync_sel_diff(sel_diff),
    .sysref(sysref), .single_ended_sync_request_pin_b(se_b), .differential_marker_pair_b(diff_b),
    .sample_data(sample_data), .sample_ready(sample_ready), .lane_group_a(grp_a), .lane_group_b(grp_b),
    .lane_is_k(lane_is_k), .lane_valid(lane_valid), .lane_mode_64b(lane_mode_64b),
    .fec_active(fec_active), .link_data(link_data), .sysref_seen(sysref_seen));
  sct_rx_model #(.PERIOD(P8)) sct_rx_model_inst (.clk(clk), .rst_b(rst_b), .sysref(sysref),
    .want_link(want), .use_diff(sel_diff), .comma_seen(lane_is_k[0]), .se_b(se_b), .diff_b(diff_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk_vec(input logic [65:0] got, input logic [65:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sysref();
    chk_bit(lane_valid, 1'b0, "valid in reset state");
    @(posedge clk);
    chk_bit(sysref_seen, 1'b0, "sysref seen before any edge");
    sysref <= 1'b1;
    repeat (3) @(posedge clk);
    sysref <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(sysref_seen, 1'b1, "sysref not seen");
  endtask
  // link bring-up on either sync pin; alignment octets must pass unscrambled
  task automatic t_cgs(input logic diff);
    sel_diff <= diff;
    sample_data <= {LANES{8'h3c}};
    scr_en <= 1'b1;
    want <= 1'b1;
    for (n = 0; n < 30 && lane_is_k !== '1; n++) @(posedge clk);
    chk_bit(lane_is_k === '1, 1'b1, "commas not on every lane");
    chk_bit(sample_ready, 1'b0, "octets taken during commas");
    for (int i = 0; i < LANES; i++)
      chk_vec(all_w[66*i +: 66], {58'h0, K28_5}, "comma octet");
    for (n = 0; n < 60 && lane_is_k !== '0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk_bit(sample_ready, 1'b1, "octets not taken in alignment");
    chk_vec(all_w[66*9 +: 66], {58'h0, 8'h3c}, "alignment octet scrambled");
    for (n = 0; n < 80 && link_data !== 1'b1; n++) @(posedge clk);
    chk_bit(link_data, 1'b1, "data phase not reached");
    repeat (3) @(posedge clk);
    chk_bit(all_w[7:0] != 8'h3c, 1'b1, "data octet not scrambled");
    scr_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk_vec(all_w[66*15 +: 66], {58'h0, 8'h3c}, "raw data octet");
    want <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_b66();
    mode_64b <= 1'b1;
    fec_en <= 1'b1;
    sample_data <= {LANES{8'ha5}};
    want <= 1'b1;
    for (n = 0; n < 60 && !(lane_valid === 1'b1 && lane_mode_64b === 1'b1); n++) @(posedge clk);
    chk_bit(lane_valid, 1'b1, "no block");
    for (int i = 0; i < LANES; i++)
      chk_vec({64'h0, all_w[66*i+64 +: 2]}, {64'h0, SH_DATA}, "sync header");
    chk_bit(all_w[63:0] != {8{8'ha5}}, 1'b1, "payload unscrambled");
    chk_bit(fec_active & lane_mode_64b, 1'b1, "fec or mode flag");
    @(posedge clk);
    for (n = 1; n < 20 && lane_valid !== 1'b1; n++) @(posedge clk);
    chk_vec(66'(n), 66'h8, "block spacing");
    chk_bit(|lane_is_k, 1'b0, "sync request obeyed in 64b");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #160000;
    fails++;
    complete_run();
  end
  initial
  begin
    fails = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    mode_64b = 1'b0;
    fec_en = 1'b0;
    scr_en = 1'b0;
    sel_diff = 1'b0;
    sysref = 1'b0;
    want = 1'b0;
    sample_data = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_sysref();
    t_cgs(1'b0);
    t_cgs(1'b1);
    t_b66();
    complete_run();
  end
endmodule
